// ===== hw/pc_stack_pkg.sv
// constants and carrier types of the program counter and call stack
package pc_stack_pkg;

  // ***************************************************************
  // widths and depths
  // ***************************************************************
  localparam int PC_W = 13;
  localparam int LOW_W = 8;
  localparam int LATCH_W = 5;
  localparam int TARGET_W = 11;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // ***************************************************************
  // register offsets
  // ***************************************************************
  localparam logic [APB_AW-1:0] ADDR_PCL = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_LATCH = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_CFG = 8'h08;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int LATCH_PAGE_BIT = 3;
  localparam int LATCH_TOP_BIT = 4;
  localparam int CFG_LARGE_BIT = 0;
  localparam int PC_PAGE_BIT = 11;
  localparam int PC_TOP_BIT = 12;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [LATCH_W-1:0] LATCH_RST = 5'h00;
  localparam logic CFG_LARGE_RST = 1'b1;
  localparam logic [SP_W-1:0] SP_RST = 3'h0;
  localparam logic [PC_W-1:0] IRQ_VECTOR_RST = 13'h0004;

  // ***************************************************************
  // decoder command set
  // ***************************************************************
  typedef enum logic [3:0] {
    OP_HOLD,
    OP_STEP,
    OP_CALL,
    OP_JUMP,
    OP_RETURN,
    OP_RET_LIT,
    OP_RET_IRQ,
    OP_IRQ,
    OP_PCL_WR,
    OP_LATCH_WR
  } core_op_t;

  typedef struct packed {
    core_op_t op;
    logic [TARGET_W-1:0] target;
    logic [LOW_W-1:0] data;
  } core_req_t;

  typedef struct packed {
    logic [PC_W-1:0] addr;
    logic valid;
  } fetch_t;

endpackage

// ===== hw/program_counter_and_call_stack.sv
// program counter, page select and circular return stack with apb access
//
// Contract
// - 13-bit counter; low byte readable and writable by software.
// - upper counter bits unreachable directly; loaded from latch on low byte writes and branches.
// - every reset clears the whole counter to zero.
// - low byte write loads latch bits 4..0 into upper bits together.
// - call and jump: 11 bits from instruction, top two from latch.
// - eight-entry 13-bit stack; pointer hidden from software.
// - push return address on call and on interrupt vectoring.
// - pop top entry into counter on the three return kinds.
// - push and pop leave the high latch untouched.
// - stack is circular; ninth push overwrites the first.
// - no overflow or underflow indication; wrap is silent.
// - latch bit 3 picks the 2K page on large parts.
// - full 13-bit counter saved and restored by the stack.
// - latch bit 4 ignored when addressing program memory.
//
// Local design decisions: the APB interface to the registers and the register offsets.
module program_counter_and_call_stack
  import pc_stack_pkg::*;
#(
  parameter logic [PC_W-1:0] IRQ_VECTOR = IRQ_VECTOR_RST
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire core_req_t core_req,
  output fetch_t fetch,
  output logic [LATCH_W-1:0] pc_high_latch
);

  // ***************************************************************
  // state
  // ***************************************************************
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [LATCH_W-1:0] latch_r;
  logic [LATCH_W-1:0] latch_nxt;
  logic large_r;
  logic large_nxt;
  logic [SP_W-1:0] sp_r;
  logic [SP_W-1:0] sp_nxt;
  logic [PC_W-1:0] stack_r [STACK_DEPTH];
  fetch_t fetch_r;
  fetch_t fetch_nxt;
  logic [APB_DW-1:0] prdata_r;
  logic [APB_DW-1:0] prdata_nxt;
  logic pready_r;
  logic pslverr_r;
  logic pslverr_nxt;

  // ***************************************************************
  // apb decode
  // ***************************************************************
  wire apb_access = psel & penable & ~pready_r;
  wire apb_commit = psel & penable & pready_r;
  wire hit_pcl = (paddr == ADDR_PCL);
  wire hit_latch = (paddr == ADDR_LATCH);
  wire hit_cfg = (paddr == ADDR_CFG);
  wire hit_any = hit_pcl | hit_latch | hit_cfg;
  wire lane0 = pstrb[0];
  wire sw_wr = apb_commit & pwrite & lane0;
  wire sw_pcl_wr = sw_wr & hit_pcl;
  wire sw_latch_wr = sw_wr & hit_latch;
  wire sw_cfg_wr = sw_wr & hit_cfg;
  wire [LOW_W-1:0] sw_byte = pwdata[LOW_W-1:0];

  // ***************************************************************
  // read mux
  // ***************************************************************
  // the counter low byte reads back live state
  wire [APB_DW-1:0] rd_pcl =
    {{(APB_DW-LOW_W){1'b0}}, pc_r[LOW_W-1:0]};
  wire [APB_DW-1:0] rd_latch =
    {{(APB_DW-LATCH_W){1'b0}}, latch_r};
  wire [APB_DW-1:0] rd_cfg =
    {{(APB_DW-1){1'b0}}, large_r};
  // upper counter bits have no read path
  wire [APB_DW-1:0] rd_word =
    hit_pcl ? rd_pcl :
    hit_latch ? rd_latch :
    hit_cfg ? rd_cfg :
    {APB_DW{1'b0}};

  always_comb begin
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (apb_access) begin
      prdata_nxt = pwrite ? {APB_DW{1'b0}} : rd_word;
      pslverr_nxt = ~hit_any;
    end
  end

  // ***************************************************************
  // decoder command decode
  // ***************************************************************
  wire op_step = (core_req.op == OP_STEP);
  wire op_call = (core_req.op == OP_CALL);
  wire op_jump = (core_req.op == OP_JUMP);
  wire op_irq = (core_req.op == OP_IRQ);
  wire op_pcl = (core_req.op == OP_PCL_WR);
  wire op_latch = (core_req.op == OP_LATCH_WR);
  wire op_ret = (core_req.op == OP_RETURN) |
                (core_req.op == OP_RET_LIT) |
                (core_req.op == OP_RET_IRQ);
  // illegal codes neither move the counter nor raise a fetch
  wire core_moves = op_step | op_call | op_jump | op_irq | op_pcl |
                    op_latch | op_ret;

  // ***************************************************************
  // core request gating
  // ***************************************************************
  // software write to the low byte overrides the decoder this cycle
  wire core_live = ~sw_pcl_wr;
  wire do_push = core_live & (op_call | op_irq);
  wire do_pop = core_live & op_ret;
  // bus write to the latch wins over a decoder write in the same cycle
  wire core_latch_wr = core_live & op_latch & ~sw_latch_wr;

  // ***************************************************************
  // address sources
  // ***************************************************************
  // sequential advance wraps inside 13 bits
  wire [PC_W-1:0] pc_inc = PC_W'(pc_r + 1'b1);

  // low byte write forms the full target from all latch bits
  wire [LOW_W-1:0] core_byte = core_req.data;
  wire [PC_W-1:0] pcl_target_core = {latch_r, core_byte};
  wire [PC_W-1:0] pcl_target_sw = {latch_r, sw_byte};

  // a computed jump arrives as a new low byte; no carry into upper bits

  // branch target: two page bits from the latch, 11 from the opcode
  wire [1:0] branch_hi =
    latch_r[LATCH_TOP_BIT:LATCH_PAGE_BIT];
  wire [PC_W-1:0] branch_target =
    {branch_hi, core_req.target};

  // return address pushed with the whole counter width
  wire [PC_W-1:0] push_value = op_irq ? pc_r : pc_inc;

  // ***************************************************************
  // stack pointer and top entry
  // ***************************************************************
  // pointer wraps modulo depth; no flag on over or underflow
  wire [SP_W-1:0] sp_up = SP_W'(sp_r + 1'b1);
  wire [SP_W-1:0] sp_down = SP_W'(sp_r - 1'b1);
  wire [PC_W-1:0] stack_top = stack_r[sp_down];

  always_comb begin
    sp_nxt = sp_r;
    if (do_push) begin
      sp_nxt = sp_up;
    end else if (do_pop) begin
      sp_nxt = sp_down;
    end
  end

  // ***************************************************************
  // program counter next value
  // ***************************************************************
  always_comb begin
    pc_nxt = pc_r;
    if (sw_pcl_wr) begin
      pc_nxt = pcl_target_sw;
    end else begin
      unique case (core_req.op)
        OP_HOLD: begin
          pc_nxt = pc_r;
        end
        OP_STEP: begin
          pc_nxt = pc_inc;
        end
        OP_LATCH_WR: begin
          pc_nxt = pc_inc;
        end
        OP_CALL: begin
          pc_nxt = branch_target;
        end
        OP_JUMP: begin
          pc_nxt = branch_target;
        end
        OP_IRQ: begin
          pc_nxt = IRQ_VECTOR;
        end
        OP_RETURN: begin
          pc_nxt = stack_top;
        end
        OP_RET_LIT: begin
          pc_nxt = stack_top;
        end
        OP_RET_IRQ: begin
          pc_nxt = stack_top;
        end
        OP_PCL_WR: begin
          pc_nxt = pcl_target_core;
        end
        default: begin
          pc_nxt = pc_r;
        end
      endcase
    end
  end

  // ***************************************************************
  // latch and configuration next values
  // ***************************************************************
  // only explicit writes change the latch, never stack traffic
  always_comb begin
    latch_nxt = latch_r;
    if (sw_latch_wr) begin
      latch_nxt = sw_byte[LATCH_W-1:0];
    end else if (core_latch_wr) begin
      latch_nxt = core_byte[LATCH_W-1:0];
    end
  end

  always_comb begin
    large_nxt = large_r;
    if (sw_cfg_wr) begin
      large_nxt = sw_byte[CFG_LARGE_BIT];
    end
  end

  // ***************************************************************
  // fetch address
  // ***************************************************************
  // page bit honoured only on large parts; top bit never addresses
  wire page_bit = large_r & pc_nxt[PC_PAGE_BIT];
  wire [PC_W-1:0] fetch_addr =
    {1'b0, page_bit, pc_nxt[TARGET_W-1:0]};
  wire moved = sw_pcl_wr | core_moves;

  always_comb begin
    fetch_nxt.addr = fetch_addr;
    fetch_nxt.valid = moved;
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pc_r <= PC_RST;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // fetch register carries the next address so memory sees it early
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fetch_r <= '0;
    end else begin
      fetch_r <= fetch_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      latch_r <= LATCH_RST;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // part size defaults to the large part
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      large_r <= CFG_LARGE_RST;
    end else begin
      large_r <= large_nxt;
    end
  end

  // pointer lives only here; no bus path reaches it
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sp_r <= SP_RST;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  // ***************************************************************
  // stack storage
  // ***************************************************************
  // entry at the pointer is overwritten on push, oldest lost on wrap
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_r[i] <= PC_RST;
      end
    end else if (do_push) begin
      stack_r[sp_r] <= push_value;
    end
  end

  // read data stays put until the next access starts; a write access loads zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prdata_r <= '0;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  // one wait state: ready follows the first access cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= apb_access;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= pslverr_nxt;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign fetch = fetch_r;
  assign pc_high_latch = latch_r;

endmodule

// ===== dv/pc_stack_monitor.sv
// concurrent checks on the program counter and call stack ports
module pc_stack_monitor
  import pc_stack_pkg::*;
#(
  parameter logic [PC_W-1:0] IRQ_VECTOR = IRQ_VECTOR_RST
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [APB_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire core_req_t core_req,
  input wire fetch_t fetch,
  input wire logic [LATCH_W-1:0] pc_high_latch
);
  // ************************************
  // software commits and checks
  // ************************************
  logic done;
  logic sw_pcl;
  logic calm;
  assign done = psel && penable && pready && pwrite && pstrb[0];
  assign sw_pcl = done && paddr == ADDR_PCL;
  assign calm = !sw_pcl;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_apb_wait: assert property (psel && penable && !pready
    |=> pready) else $error("access not answered");
  chk_reset_zero: assert property ($fell(reset)
    |-> fetch.addr == PC_RST && !fetch.valid) else $error("pc not cleared");
  chk_pcl_load: assert property (sw_pcl |=> fetch.valid &&
    fetch.addr[10:0] == {$past(pc_high_latch[2:0]), $past(pwdata[7:0])})
    else $error("low byte load wrong");
  chk_branch_target: assert property (calm &&
    core_req.op inside {OP_CALL, OP_JUMP}
    |=> fetch.addr[10:0] == $past(core_req.target)) else $error("bad target");
  chk_irq_vector: assert property (calm && core_req.op == OP_IRQ
    |=> fetch.valid && fetch.addr[10:0] == IRQ_VECTOR[10:0])
    else $error("bad vector");
  chk_latch_kept: assert property (!done && core_req.op inside
    {OP_CALL, OP_IRQ, OP_RETURN, OP_RET_LIT, OP_RET_IRQ}
    |=> $stable(pc_high_latch)) else $error("latch moved");
  chk_top_masked: assert property (fetch.valid
    |-> !fetch.addr[PC_TOP_BIT]) else $error("top bit reached memory");
  chk_step_one: assert property (calm && core_req.op == OP_STEP
    |=> fetch.addr[10:0] == $past(fetch.addr[10:0]) + 11'h001)
    else $error("step wrong");
  chk_hold_quiet: assert property (calm && core_req.op == OP_HOLD
    |=> !fetch.valid && $stable(fetch.addr[10:0])) else $error("hold moved");
  cover property (core_req.op == OP_CALL);
  cover property (sw_pcl);
  cover property (pready && pslverr);
endmodule

bind program_counter_and_call_stack pc_stack_monitor #(
  .IRQ_VECTOR(IRQ_VECTOR)
) pc_stack_monitor_i (
  .clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .core_req, .fetch, .pc_high_latch
);

// ===== dv/core_sequencer.sv
// behavioural instruction decoder issuing one core request per call
module core_sequencer
  import pc_stack_pkg::*;
(
  input wire logic clk_sys,
  output core_req_t core_req
);
  timeunit 1ns;
  timeprecision 100ps;
  initial core_req = '{op: OP_HOLD, target: '0, data: '0};
  // caller sets page bit and low byte sums first
  task automatic issue(input core_op_t o, input logic [TARGET_W-1:0] t,
      input logic [LOW_W-1:0] d);
    @(posedge clk_sys);
    core_req <= '{op: o, target: t, data: d};
    @(posedge clk_sys);
    core_req <= '{op: OP_HOLD, target: ~t, data: ~d};
  endtask
endmodule

// ===== dv/program_counter_and_call_stack_bench.sv
// self-checking bench of the program counter and call stack
module program_counter_and_call_stack_bench
  import pc_stack_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [APB_DW-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [APB_DW-1:0] prdata;
  logic pready;
  logic pslverr;
  core_req_t core_req;
  fetch_t fetch;
  logic [LATCH_W-1:0] pc_high_latch;
  int n_fail = 0;
  int tests_run = 0;
  logic [PC_W-1:0] exp_pc = '0;
  logic [PC_W-1:0] stk [STACK_DEPTH] = '{default: '0};
  logic [SP_W-1:0] sp = '0;
  logic [LATCH_W-1:0] latch_m = '0;
  logic large_m = 1'b1;
  logic [APB_DW-1:0] rd;
  logic err;
  core_op_t rets [3] = '{OP_RETURN, OP_RET_LIT, OP_RET_IRQ};
  always #2.5 clk_sys = ~clk_sys;
  program_counter_and_call_stack program_counter_and_call_stack_i (
    .clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .core_req, .fetch, .pc_high_latch
  );
  core_sequencer core_sequencer_i (.clk_sys, .core_req);
  function automatic logic [PC_W-1:0] vis(input logic [PC_W-1:0] p);
    return {1'b0, p[PC_PAGE_BIT] & large_m, p[10:0]};
  endfunction
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [APB_AW-1:0] a,
      input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (k = 0; k < 16 && pready !== 1'b1; k++) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 16) begin
      n_fail++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d,
      input logic [3:0] s);
    logic miss;
    miss = !(a inside {ADDR_PCL, ADDR_LATCH, ADDR_CFG});
    apb(1'b1, a, d, s);
    if (s[0] && a == ADDR_PCL) exp_pc = {latch_m, d[7:0]};
    if (s[0] && a == ADDR_LATCH) latch_m = d[4:0];
    if (s[0] && a == ADDR_CFG) large_m = d[0];
    #1;
    if (a == ADDR_PCL) `CHK("fetch", vis(exp_pc), fetch.addr)
    `CHK("latch", latch_m, pc_high_latch)
    `CHK("slverr", miss, err)
  endtask
  task automatic rdc(input logic [APB_AW-1:0] a, input logic [31:0] e,
      input logic ee);
    apb(1'b0, a, 32'h0, 4'h0);
    `CHK("rdata", e, rd)
    `CHK("slverr", ee, err)
  endtask
  task automatic issue(input core_op_t o, input logic [TARGET_W-1:0] t,
      input logic [LOW_W-1:0] d);
    logic [PC_W-1:0] nxt;
    nxt = exp_pc + 13'h1;
    if (o == OP_CALL || o == OP_IRQ) begin
      stk[sp] = (o == OP_IRQ) ? exp_pc : nxt;
      sp++;
    end
    if (o inside {OP_RETURN, OP_RET_LIT, OP_RET_IRQ}) begin
      sp--;
      nxt = stk[sp];
    end
    if (o inside {OP_CALL, OP_JUMP}) nxt = {latch_m[4:3], t};
    if (o == OP_IRQ) nxt = IRQ_VECTOR_RST;
    if (o == OP_PCL_WR) nxt = {latch_m, d};
    if (o == OP_LATCH_WR) latch_m = d[4:0];
    if (o != OP_HOLD) exp_pc = nxt;
    core_sequencer_i.issue(o, t, d);
    #1;
    `CHK("fetch", vis(exp_pc), fetch.addr)
    `CHK("valid", o != OP_HOLD, fetch.valid)
    `CHK("latch", latch_m, pc_high_latch)
  endtask
  // ************************************
  // main sequence
  // ************************************
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    `CHK("fetch", 13'h0000, fetch.addr)
    rdc(ADDR_PCL, 32'h0, 1'b0);
    rdc(ADDR_LATCH, 32'h0, 1'b0);
    rdc(ADDR_CFG, 32'h1, 1'b0);
    rdc(8'h0C, 32'h0, 1'b1);
    issue(OP_STEP, 11'h0, 8'h0);
    issue(OP_HOLD, 11'h0, 8'h0);
    wr(ADDR_LATCH, 32'h1A, 4'h1);
    wr(ADDR_PCL, 32'h34, 4'h0);
    wr(ADDR_PCL, 32'h34, 4'hF);
    wr(8'h0C, 32'hFF, 4'hF);
    rdc(ADDR_PCL, 32'h34, 1'b0);
    rdc(ADDR_LATCH, 32'h1A, 1'b0);
    issue(OP_PCL_WR, 11'h0, 8'hF0 + 8'h20);
    issue(OP_CALL, 11'h123, 8'h0);
    for (int i = 0; i < 9; i++) issue(OP_CALL, 11'(i * 64), 8'h0);
    issue(OP_IRQ, 11'h0, 8'h0);
    issue(OP_LATCH_WR, 11'h0, 8'h00);
    for (int i = 0; i < 12; i++) issue(rets[i % 3], 11'h0, 8'h0);
    wr(ADDR_CFG, 32'h0, 4'hF);
    issue(OP_LATCH_WR, 11'h0, 8'h0F);
    issue(OP_JUMP, 11'h7FF, 8'h0);
    issue(OP_STEP, 11'h0, 8'h0);
    issue(OP_STEP, 11'h0, 8'h0);
    // second reset in mid-run clears counter, latch and stack and restores the large part size
    @(posedge clk_sys);
    reset <= 1'b1;
    exp_pc = '0;
    sp = '0;
    latch_m = '0;
    large_m = 1'b1;
    stk = '{default: '0};
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    `CHK("fetch", 13'h0000, fetch.addr)
    rdc(ADDR_LATCH, 32'h0, 1'b0);
    rdc(ADDR_CFG, 32'h1, 1'b0);
    issue(OP_RETURN, 11'h0, 8'h0);
    rdc(ADDR_PCL, 32'h0, 1'b0);
    end_sim();
  end
endmodule
